// *** common/bert_consts.svh ***
// register offsets, field positions, reset values and timing counts of the test block
`ifndef BERT_CONSTS_SVH
`define BERT_CONSTS_SVH

// register byte addresses
`define ADDR_CTRL 8'h20
`define ADDR_PAT_LO 8'h24
`define ADDR_PAT_HI 8'h28
`define ADDR_BC_HI 8'h2C
`define ADDR_BC_LO 8'h30
`define ADDR_EC0 8'h34
`define ADDR_EC1 8'h38

// control register fields
`define CTRL_LOAD 0
`define CTRL_TOP_MASK 8
`define CTRL_OVF_IE 13
`define CTRL_ERR_IE 14
`define CTRL_SYNC_IE 15

// error-count low / status register fields
`define ST_SYNC 0
`define ST_ECO 1
`define ST_BCO 2
`define ST_BED 3
`define ST_LOCK_LOST_FLAG 4
`define ST_RA0 5
`define ST_RA1 6

// reset values
`define CTRL_RESET 16'h0000
`define PAT_RESET 16'h0000
`define LOCK_LOST_FLAG_RESET 1'b1

// synchroniser and detector figures
`define LOCK_MATCHES 32
`define WIN_BITS 64
`define WIN_ERR_LIMIT 6
`define RUN_LEN 31

// update cycle timing
`define CLK_PERIOD_NS 50
`define UPDATE_NS 475
`define UPDATE_CYC ((`UPDATE_NS) / (`CLK_PERIOD_NS))

`endif

// *** common/bert_pkg.sv ***
// types shared by the test block modules
package bert_pkg;

   typedef enum logic {HUNT, LOCKED} sync_state_e;

   typedef struct packed {
      sync_state_e mode;
      logic [4:0] idx;
      logic [5:0] matchCnt;
      logic [5:0] winCnt;
      logic [2:0] winErr;
      logic bitErr;
      logic searchStart;
   } sync_state_s;

   typedef struct packed {
      logic [15:0] ctrl;
      logic [15:0] patLo;
      logic [15:0] patHi;
      logic updBusy;
      logic [3:0] updCnt;
      logic counting;
      logic [31:0] bcHold;
      logic [23:0] ecHold;
      logic eco;
      logic bco;
      logic bed;
      logic lock_lost_flag;
      logic ra0;
      logic ra1;
      logic [4:0] zeroRun;
      logic [4:0] oneRun;
      logic lockPrev;
      logic lockChg;
      logic [15:0] rdData;
      logic irq;
   } top_state_s;

endpackage

// *** common/sat_count_if.sv ***
// handshake between the block and one saturating counter
`timescale 1ns/100ps
interface sat_count_if #(parameter int W = 32);
   logic inc;
   logic clr;
   logic [W-1:0] value;
   logic satHit;

   modport owner (output inc, output clr, input value, input satHit);
   modport cnt (input inc, input clr, output value, output satHit);
endinterface

// *** core/sat_counter.sv ***
// saturating up counter with a one-cycle saturation event
`timescale 1ns/100ps
module sat_counter #(parameter int W = 32) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // counter handshake
   sat_count_if.cnt cnt
);
   typedef struct packed {
      logic [W-1:0] value;
      logic satHit;
   } cnt_state_s;

   localparam logic [W-1:0] MAXV = '1;

   cnt_state_s st;
   cnt_state_s nx;

   // clear wins, otherwise count and stop at all ones
   always_comb begin
      nx = st;
      nx.satHit = 1'b0;
      if (cnt.clr) begin
         nx.value = '0;
      end else if (cnt.inc && st.value != MAXV) begin
         nx.value = st.value + 1'b1;
         nx.satHit = (st.value == MAXV - 1'b1);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= nx;
      end
   end

   assign cnt.value = st.value;
   assign cnt.satHit = st.satHit;

   // counter only moves up unless cleared
   no_wrap_a: assert property (@(posedge ref_clk) disable iff (rst)
      !$past(cnt.clr) |-> st.value >= $past(st.value))
      else $error("counter wrapped or fell");
endmodule

// *** core/pattern_sync.sv ***
// receive pattern synchroniser: hunts, locks, watches error density
`timescale 1ns/100ps
module pattern_sync
   import bert_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // receive stream
   input wire logic rxBitStrobe,
   input wire logic rxBit,
   input wire logic [31:0] pattern,
   // results
   output logic locked,
   output logic bitErr,
   output logic searchStart
);
   `include "bert_consts.svh"

   sync_state_s st;
   sync_state_s nx;
   logic expBit;

   // first bit of the stream sits at pattern bit 0
   assign expBit = pattern[st.idx];

   // hunt by slipping on mismatch, then track error density
   always_comb begin
      nx = st;
      nx.bitErr = 1'b0;
      nx.searchStart = 1'b0;
      if (rxBitStrobe) begin
         case (st.mode)
            HUNT: begin
               if (rxBit == expBit) begin
                  nx.idx = st.idx + 5'd1;
                  nx.matchCnt = st.matchCnt + 6'd1;
                  if (st.matchCnt == 6'(`LOCK_MATCHES - 1)) begin
                     nx.mode = LOCKED;
                     nx.winCnt = '0;
                     nx.winErr = '0;
                  end
               end else begin
                  nx.matchCnt = '0;
               end
            end
            LOCKED: begin
               nx.idx = st.idx + 5'd1;
               nx.winCnt = st.winCnt + 6'd1;
               if (rxBit != expBit) begin
                  nx.bitErr = 1'b1;
                  nx.winErr = st.winErr + 3'd1;
               end
               if (rxBit != expBit && st.winErr == 3'(`WIN_ERR_LIMIT - 1)) begin
                  nx.mode = HUNT;
                  nx.matchCnt = '0;
                  nx.searchStart = 1'b1;
               end else if (st.winCnt == 6'(`WIN_BITS - 1)) begin
                  nx.winErr = '0;
               end
            end
            default: begin
               nx.mode = HUNT;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= nx;
      end
   end

   assign locked = (st.mode == LOCKED);
   assign bitErr = st.bitErr;
   assign searchStart = st.searchStart;

   // lock only after a full run of matches
   lock_after_run_a: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(locked) |-> $past(st.matchCnt) == 6'd31)
      else $error("lock without 32 matches");

   // errors reported only while locked
   err_when_locked_a: assert property (@(posedge ref_clk) disable iff (rst)
      bitErr |-> $past(locked))
      else $error("bit error outside lock");
endmodule

// *** core/bert_rx_top.sv ***
// receive bit-error-rate tester: pattern, counters and status
// Functional notes
// - Two pattern words form one 32-bit pattern, bit 0 first, for sync.
// - Received-bit counter is 32 bits, saturates, flags overflow.
// - Counting starts at first lock and continues after lock loss.
// - Toggling load-counters clears the running counters.
// - Load-counters rising edge starts update; host waits 475 ns.
// - Lock after 32 matches, lost at six errors in 64, lock change may interrupt.
// - Error overflow flag latched on saturation, cleared on read.
// - Bit overflow flag latched on saturation, cleared on read.
// - Overflow interrupts need overflow enable and top mask set.
// - Bit-error flag latched while locked, cleared on read, may interrupt.
// - Lock-lost flag resets set, set on search, lock change interrupts.
// - All-zeros flag after 31 zeros, cleared on read after a one, no interrupt.
// - All-ones flag after 31 ones, cleared on read after a zero, no interrupt.
// - Error counter low byte reads in status register bits 15 to 8.
// - Error counter is 24 bits, saturating, upper word separate.
//
// Added by the designer: strobed register access.
`timescale 1ns/100ps
module bert_rx_top
   import bert_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // register port
   input wire logic [7:0] addr,
   input wire logic [15:0] wrData,
   input wire logic wrEn,
   input wire logic rdEn,
   output logic [15:0] rdData,
   // receive stream
   input wire logic rxBitStrobe,
   input wire logic rxBit,
   // interrupt request
   output logic irq
);
   `include "bert_consts.svh"

   top_state_s st;
   top_state_s nx;
   logic syncLocked;
   logic syncBitErr;
   logic syncSearch;
   logic updDone;
   logic ec0Read;
   logic zeroIn;
   logic oneIn;

   sat_count_if #(.W(32)) bitCnt ();
   sat_count_if #(.W(24)) errCnt ();

   // bit counter and error counter
   sat_counter #(.W(32)) bitCounter (
      .ref_clk(ref_clk),
      .rst(rst),
      .cnt(bitCnt.cnt)
   );

   sat_counter #(.W(24)) errCounter (
      .ref_clk(ref_clk),
      .rst(rst),
      .cnt(errCnt.cnt)
   );

   // synchroniser against the loaded pattern
   pattern_sync syncer (
      .ref_clk(ref_clk),
      .rst(rst),
      .rxBitStrobe(rxBitStrobe),
      .rxBit(rxBit),
      .pattern({st.patHi, st.patLo}),
      .locked(syncLocked),
      .bitErr(syncBitErr),
      .searchStart(syncSearch)
   );

   // counter drive: count from first lock, clear at update end
   assign updDone = st.updBusy && (st.updCnt == 4'(`UPDATE_CYC - 1));
   assign bitCnt.inc = (st.counting || syncLocked) && rxBitStrobe;
   assign bitCnt.clr = updDone;
   assign errCnt.inc = syncBitErr;
   assign errCnt.clr = updDone;

   // helper terms
   assign ec0Read = rdEn && (addr == `ADDR_EC0);
   assign zeroIn = rxBitStrobe && !rxBit;
   assign oneIn = rxBitStrobe && rxBit;

   // next state of registers, flags and update sequencer
   always_comb begin
      nx = st;

      // software writes
      if (wrEn) begin
         case (addr)
            `ADDR_CTRL: nx.ctrl = wrData;
            `ADDR_PAT_LO: nx.patLo = wrData;
            `ADDR_PAT_HI: nx.patHi = wrData;
            default: nx = nx;
         endcase
      end

      // rising load-counters starts an update of fixed length
      if (nx.ctrl[`CTRL_LOAD] && !st.ctrl[`CTRL_LOAD] && !st.updBusy) begin
         nx.updBusy = 1'b1;
         nx.updCnt = '0;
      end else if (updDone) begin
         nx.updBusy = 1'b0;
         nx.bcHold = bitCnt.value;
         nx.ecHold = errCnt.value;
      end else if (st.updBusy) begin
         nx.updCnt = st.updCnt + 4'd1;
      end

      // counting, once started, survives lock loss
      nx.counting = st.counting || syncLocked;

      // read data, taken before read clears
      nx.rdData = 16'h0000;
      if (rdEn) begin
         case (addr)
            `ADDR_CTRL: nx.rdData = st.ctrl;
            `ADDR_PAT_LO: nx.rdData = st.patLo;
            `ADDR_PAT_HI: nx.rdData = st.patHi;
            `ADDR_BC_LO: nx.rdData = st.bcHold[15:0];
            `ADDR_BC_HI: nx.rdData = st.bcHold[31:16];
            `ADDR_EC1: nx.rdData = st.ecHold[23:8];
            `ADDR_EC0: begin
               nx.rdData[15:8] = st.ecHold[7:0];
               nx.rdData[`ST_RA1] = st.ra1;
               nx.rdData[`ST_RA0] = st.ra0;
               nx.rdData[`ST_LOCK_LOST_FLAG] = st.lock_lost_flag;
               nx.rdData[`ST_BED] = st.bed;
               nx.rdData[`ST_BCO] = st.bco;
               nx.rdData[`ST_ECO] = st.eco;
               nx.rdData[`ST_SYNC] = syncLocked;
            end
            default: nx.rdData = 16'h0000;
         endcase
      end

      // read of status clears the event flags; setting wins
      if (ec0Read) begin
         nx.eco = 1'b0;
         nx.bco = 1'b0;
         nx.bed = 1'b0;
         nx.lock_lost_flag = 1'b0;
         nx.lockChg = 1'b0;
      end
      if (errCnt.satHit) begin
         nx.eco = 1'b1;
      end
      if (bitCnt.satHit) begin
         nx.bco = 1'b1;
      end
      if (syncBitErr) begin
         nx.bed = 1'b1;
      end
      if (syncSearch) begin
         nx.lock_lost_flag = 1'b1;
      end

      // any change of lock state is an event
      nx.lockPrev = syncLocked;
      if (syncLocked != st.lockPrev) begin
         nx.lockChg = 1'b1;
      end

      // runs of equal bits, held at the threshold
      if (zeroIn) begin
         nx.oneRun = '0;
         if (st.zeroRun != 5'(`RUN_LEN)) begin
            nx.zeroRun = st.zeroRun + 5'd1;
         end
      end else if (oneIn) begin
         nx.zeroRun = '0;
         if (st.oneRun != 5'(`RUN_LEN)) begin
            nx.oneRun = st.oneRun + 5'd1;
         end
      end

      // all-zeros / all-ones: clear on read only once the run is broken
      if (ec0Read && nx.zeroRun != 5'(`RUN_LEN)) begin
         nx.ra0 = 1'b0;
      end
      if (ec0Read && nx.oneRun != 5'(`RUN_LEN)) begin
         nx.ra1 = 1'b0;
      end
      if (nx.zeroRun == 5'(`RUN_LEN)) begin
         nx.ra0 = 1'b1;
      end
      if (nx.oneRun == 5'(`RUN_LEN)) begin
         nx.ra1 = 1'b1;
      end

      // interrupt: flag and its enable, gated by the top mask
      nx.irq = nx.ctrl[`CTRL_TOP_MASK] &&
         ((nx.ctrl[`CTRL_OVF_IE] && (nx.eco || nx.bco)) ||
          (nx.ctrl[`CTRL_ERR_IE] && nx.bed) ||
          (nx.ctrl[`CTRL_SYNC_IE] && nx.lockChg));
   end

   // state register
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st <= '0;
         st.ctrl <= `CTRL_RESET;
         st.patLo <= `PAT_RESET;
         st.patHi <= `PAT_RESET;
         st.lock_lost_flag <= `LOCK_LOST_FLAG_RESET;
      end else begin
         st <= nx;
      end
   end

   assign rdData = st.rdData;
   assign irq = st.irq;

   // load-counters edge clears counters within the update window
   update_window_a: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(st.updBusy) |-> ##[1:9] bitCnt.clr)
      else $error("update did not complete in time");

   // update snapshots the bit count, then the cleared counter reads zero
   clear_snapshot_a: assert property (@(posedge ref_clk) disable iff (rst)
      updDone |=> (st.bcHold == $past(bitCnt.value)) && bitCnt.value == 32'h0)
      else $error("update did not snapshot and clear");

   // bit counter saturation latches its flag
   bit_ovf_a: assert property (@(posedge ref_clk) disable iff (rst)
      bitCnt.satHit |=> st.bco)
      else $error("bit overflow flag missed");

   // error counter saturation latches its flag
   err_ovf_a: assert property (@(posedge ref_clk) disable iff (rst)
      errCnt.satHit |=> st.eco)
      else $error("error overflow flag missed");

   // detected error latches the flag and counts
   bit_error_a: assert property (@(posedge ref_clk) disable iff (rst)
      syncBitErr && errCnt.value != 24'hFFFFFF && !updDone
      |=> st.bed && errCnt.value == $past(errCnt.value) + 24'h000001)
      else $error("bit error not recorded");

   // search start sets lock-lost flag
   lock_lost_a: assert property (@(posedge ref_clk) disable iff (rst)
      syncSearch |=> st.lock_lost_flag)
      else $error("lock lost flag not set");

   // 31 zeros raise all-zeros
   all_zeros_a: assert property (@(posedge ref_clk) disable iff (rst)
      st.zeroRun == 5'd30 && zeroIn |=> st.ra0)
      else $error("all zeros flag missed");

   // 31 ones raise all-ones
   all_ones_a: assert property (@(posedge ref_clk) disable iff (rst)
      st.oneRun == 5'd30 && oneIn |=> st.ra1)
      else $error("all ones flag missed");

   // masked block never interrupts
   irq_mask_a: assert property (@(posedge ref_clk) disable iff (rst)
      !st.ctrl[`CTRL_TOP_MASK] |-> !irq)
      else $error("interrupt while masked");

   // status read returns error low byte and live lock
   status_read_a: assert property (@(posedge ref_clk) disable iff (rst)
      ec0Read |=> rdData[15:8] == $past(st.ecHold[7:0]) &&
      rdData[0] == $past(syncLocked))
      else $error("status read mismatch");

   // main scenarios
   lock_cov: cover property (@(posedge ref_clk) disable iff (rst) $rose(syncLocked));
   relock_cov: cover property (@(posedge ref_clk) disable iff (rst) syncSearch);
   update_cov: cover property (@(posedge ref_clk) disable iff (rst) updDone);
   irq_cov: cover property (@(posedge ref_clk) disable iff (rst) $rose(irq));
endmodule

// *** test/bit_source.sv ***
// bit source standing in for the framer receive stream
`timescale 1ns/100ps
module bit_source (
   // clock
   input wire logic ref_clk,
   // pattern that the stream repeats
   input wire logic [31:0] pattern,
   // receive stream
   output logic rxBitStrobe,
   output logic rxBit
);
   logic [4:0] idx = 5'h00;

   // line idle and low at time zero
   initial begin
      rxBitStrobe = 1'b0;
      rxBit = 1'b0;
   end

   // n bits, every errEvery-th inverted; the line flips between strobes so
   // that a stale level is never mistaken for data
   task automatic send(input int n, input int errEvery);
      for (int k = 0; k < n; k++) begin
         @(posedge ref_clk);
         rxBitStrobe <= 1'b1;
         rxBit <= pattern[idx] ^ (errEvery != 0 && k % errEvery == errEvery - 1);
         idx <= idx + 5'h01;
         @(posedge ref_clk);
         rxBitStrobe <= 1'b0;
         rxBit <= ~rxBit;
      end
   endtask
endmodule

// *** test/bert_pattern_counters_status_bench.sv ***
// self-checking bench of the receive test block
`timescale 1ns/100ps
`include "bert_consts.svh"
`define CHK(g, e) begin \
   n_tests++; \
   if ((g) !== (e)) begin \
      failures++; \
      $display("Error at %0t: got %h expected %h", $time, (g), (e)); \
   end \
end
module bert_pattern_counters_status_bench;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [15:0] wrData = 16'h0000;
   logic wrEn = 1'b0;
   logic rdEn = 1'b0;
   logic [15:0] rdData;
   logic rxBitStrobe;
   logic rxBit;
   logic irq;
   logic [15:0] patLo = 16'h0000;
   logic [15:0] patHi = 16'h0000;
   logic [15:0] ctrlVal = 16'h0000;
   logic [7:0] zeroAddr [6] = '{`ADDR_PAT_LO, `ADDR_PAT_HI, `ADDR_BC_HI, `ADDR_BC_LO,
      `ADDR_EC1, 8'h00};
   logic [31:0] patTab [3] = '{32'hFFFFFFFF, 32'h7E7E0000, 32'h5AD6B5AD};
   int failures = 0;
   int n_tests = 0;

   // device and stream source
   bert_rx_top i_bert_rx_top (
      .ref_clk(ref_clk), .rst(rst), .addr(addr), .wrData(wrData), .wrEn(wrEn),
      .rdEn(rdEn), .rdData(rdData), .rxBitStrobe(rxBitStrobe), .rxBit(rxBit), .irq(irq)
   );
   bit_source i_bit_source (
      .ref_clk(ref_clk), .pattern({patHi, patLo}), .rxBitStrobe(rxBitStrobe),
      .rxBit(rxBit)
   );

   // 20 MHz clock
   initial begin
      forever #25 ref_clk = ~ref_clk;
   end

   // one-cycle write strobe
   task automatic regWrite(input logic [7:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      addr <= a;
      wrData <= d;
      wrEn <= 1'b1;
      @(posedge ref_clk);
      wrEn <= 1'b0;
   endtask

   // one-cycle read strobe, data taken in the following cycle
   task automatic regRead(input logic [7:0] a, output logic [15:0] d);
      @(posedge ref_clk);
      addr <= a;
      rdEn <= 1'b1;
      @(posedge ref_clk);
      rdEn <= 1'b0;
      #1 d = rdData;
   endtask

   // read and compare the masked value
   task automatic checkReg(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
      logic [15:0] d;
      regRead(a, d);
      `CHK(d & m, e)
   endtask

   // load-counters rising edge, then the wait before counts may be read
   task automatic update();
      regWrite(`ADDR_CTRL, ctrlVal);
      regWrite(`ADDR_CTRL, ctrlVal | 16'h0001);
      repeat (10) @(posedge ref_clk);
   endtask

   // end-of-test line
   task automatic endTest(input string name);
      $display("test %s done", name);
   endtask

   // verdict and end of run
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // watchdog well past the expected run of some 3800 cycles
   initial begin
      #1000000;
      failures++;
      stop_test();
   end

   // test sequence
   initial begin
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      regWrite(`ADDR_BC_LO, 16'h1234);
      checkReg(`ADDR_CTRL, 16'hFFFF, `CTRL_RESET);
      checkReg(`ADDR_EC0, 16'hFFFF, 16'h0010);
      foreach (zeroAddr[i]) checkReg(zeroAddr[i], 16'hFFFF, 16'h0000);
      endTest("reset");
      // repeated, all ones, two words
      foreach (patTab[i]) begin
         {patHi, patLo} = patTab[i];
         regWrite(`ADDR_PAT_LO, patLo);
         regWrite(`ADDR_PAT_HI, patHi);
         checkReg(`ADDR_PAT_LO, 16'hFFFF, patLo);
         checkReg(`ADDR_PAT_HI, 16'hFFFF, patHi);
      end
      endTest("pattern");
      i_bit_source.send(1500, 0);
      checkReg(`ADDR_EC0, 16'h0001, 16'h0001);
      update();
      endTest("lock");
      // 100 bits with three errors, then a stable snapshot
      i_bit_source.send(100, 33);
      update();
      checkReg(`ADDR_BC_HI, 16'hFFFF, 16'h0000);
      checkReg(`ADDR_BC_LO, 16'hFFFF, 16'h0064);
      checkReg(`ADDR_EC0, 16'hFFEF, 16'h0309);
      checkReg(`ADDR_EC1, 16'hFFFF, 16'h0000);
      checkReg(`ADDR_EC0, 16'hFFEF, 16'h0301);
      i_bit_source.send(40, 0);
      checkReg(`ADDR_BC_LO, 16'hFFFF, 16'h0064);
      endTest("counting");
      // error interrupt with and without the top mask
      ctrlVal = 16'h4100;
      regWrite(`ADDR_CTRL, ctrlVal);
      checkReg(`ADDR_CTRL, 16'hFFFF, 16'h4100);
      i_bit_source.send(1, 1);
      repeat (6) @(posedge ref_clk);
      `CHK(irq, 1'b1)
      checkReg(`ADDR_EC0, 16'h0008, 16'h0008);
      repeat (2) @(posedge ref_clk);
      `CHK(irq, 1'b0)
      ctrlVal = 16'h4000;
      regWrite(`ADDR_CTRL, ctrlVal);
      i_bit_source.send(1, 1);
      repeat (6) @(posedge ref_clk);
      `CHK(irq, 1'b0)
      checkReg(`ADDR_EC0, 16'h0008, 16'h0008);
      endTest("interrupt");
      // dense errors drop lock, counting goes on
      ctrlVal = 16'h8100;
      update();
      i_bit_source.send(128, 4);
      `CHK(irq, 1'b1)
      update();
      checkReg(`ADDR_BC_LO, 16'hFFFF, 16'h0080);
      checkReg(`ADDR_EC0, 16'h0011, 16'h0010);
      repeat (2) @(posedge ref_clk);
      `CHK(irq, 1'b0)
      checkReg(`ADDR_EC0, 16'h0010, 16'h0000);
      endTest("lock_loss");
      // runs of 30 and 31 equal bits
      ctrlVal = 16'hE100;
      regWrite(`ADDR_CTRL, ctrlVal);
      for (int v = 0; v < 2; v++) begin
         {patHi, patLo} = {32{v[0]}};
         regWrite(`ADDR_PAT_LO, patLo);
         regWrite(`ADDR_PAT_HI, patHi);
         i_bit_source.send(1, 1);
         i_bit_source.send(30, 0);
         checkReg(`ADDR_EC0, 16'h0020 << v, 16'h0000);
         i_bit_source.send(1, 0);
         checkReg(`ADDR_EC0, 16'h0020 << v, 16'h0020 << v);
      end
      `CHK(irq, 1'b0)
      endTest("runs");
      stop_test();
   end
endmodule
